/* bench/swp_dac_model.sv */
// Purpose: converter model, counts words per channel
// Assumes: one strobe per delivered word
// Notes:   count lets the bench spot stray output
`timescale 1ns/1ns

module swp_dac_model #(
  parameter int NUM_CH = 2
) (
  input  wire logic                 core_clk_in,
  input  wire logic [NUM_CH*16-1:0] dac_data_in,
  input  wire logic [NUM_CH-1:0]    dac_valid_in,
  output logic      [NUM_CH*16-1:0] level_out,
  output logic      [NUM_CH*16-1:0] seen_out
);
  initial seen_out = '0;
  // latch each word whole and unscaled, count strobes
  always @(posedge core_clk_in) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (dac_valid_in[c] === 1'b1) begin
        level_out[c*16 +: 16] <= dac_data_in[c*16 +: 16];
        seen_out[c*16 +: 16] <= seen_out[c*16 +: 16] + 16'h1;
      end
    end
  end
endmodule

/* bench/swp_top_asserts.sv */
// Purpose: port checks for swp_top
// Assumes: sample tick every cycle, at least two channels
// Notes:   bound into every swp_top
`timescale 1ns/1ns
`include "swp_defs.svh"

module swp_top_chk #(
  parameter int NUM_CH = 2
) (
  input wire logic                   core_clk_in,
  input wire logic                   srst_in,
  input wire logic                   seg_del_in,
  input wire logic [NUM_CH-1:0]      run_in,
  input wire logic [NUM_CH*12-1:0]   act_seg_in,
  input wire logic [NUM_CH*16-1:0]   dac_data_out,
  input wire logic [NUM_CH-1:0]      dac_valid_out,
  input wire logic [NUM_CH-1:0]      seg_empty_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_rst;
    $fell(srst_in) |-> dac_valid_out == '0 && seg_empty_out == '1;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs busy after reset");
  property p_idle;
    !run_in[0] [*3] |-> !dac_valid_out[0];
  endproperty
  a_idle: assert property (p_idle) else $error("strobe while stopped");
  property p_empty;
    seg_empty_out[0] [*2] |-> !dac_valid_out[0];
  endproperty
  a_empty: assert property (p_empty) else $error("strobe from empty segment");
  property p_first;
    (!run_in[0] ##1 (run_in[0] && !seg_empty_out[0] && $stable(act_seg_in[11:0])) [*3])
      |-> dac_valid_out[0];
  endproperty
  a_first: assert property (p_first) else $error("first word late");
  property p_hold;
    !dac_valid_out[0] && !$past(srst_in) |-> $stable(dac_data_out[15:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("word changed without strobe");
  property p_cont0;
    (run_in[0] && !seg_del_in && $stable(act_seg_in[11:0])) [*2] ##0
      (dac_valid_out[0] && !seg_empty_out[0]) |=> dac_valid_out[0];
  endproperty
  a_cont0: assert property (p_cont0) else $error("gap in channel 0");
  property p_cont1;
    (run_in[1] && !seg_del_in && $stable(act_seg_in[23:12])) [*2] ##0
      (dac_valid_out[1] && !seg_empty_out[1]) |=> dac_valid_out[1];
  endproperty
  a_cont1: assert property (p_cont1) else $error("gap in channel 1");
  property p_seg0;
    (act_seg_in[11:0] == 12'h000) [*2] |-> seg_empty_out[0];
  endproperty
  a_seg0: assert property (p_seg0) else $error("segment zero not empty");
endmodule

bind swp_top swp_top_chk #(.NUM_CH(NUM_CH)) u_chk (.core_clk_in(core_clk_in),
  .srst_in(srst_in), .seg_del_in(seg_del_in), .run_in(run_in), .act_seg_in(act_seg_in),
  .dac_data_out(dac_data_out), .dac_valid_out(dac_valid_out), .seg_empty_out(seg_empty_out));

/* bench/tb.sv */
// Purpose: self-checking bench for swp_top
// Assumes: converter model beside the player
// Notes:   driver queues expected words, watcher checks each strobe while words are queued
`timescale 1ns/1ns
`include "swp_defs.svh"

module tb;
  import swp_pkg::*;
  logic clk = 0, srst = 1, mwr = 0, swr = 0, sdel = 0;
  logic [19:0] maddr = '0, sst = '0, ssp = '0;
  swp_sample_t mdat = '0;
  swp_seg_num_t snum = '0;
  logic [1:0] run = '0, dv, semp;
  logic [23:0] act = '0;
  logic [31:0] dq, seen, lvl, rs = 32'h107c;
  swp_sample_t mem_m[int], q0[$], q1[$];
  int bs[int], be[int], n_errors = 0, n_compared = 0, cyc = 0;
  int tbl[5][3] = '{'{1, 2, 5}, '{2, 8, 10}, '{2048, 'hfffff, 'hfffff},
                    '{0, 0, 3}, '{2049, 0, 3}};

  swp_top DUT (.core_clk_in(clk), .srst_in(srst), .mem_wr_in(mwr), .mem_addr_in(maddr),
    .mem_data_in(mdat), .seg_wr_in(swr), .seg_num_in(snum), .seg_start_in(sst),
    .seg_stop_in(ssp), .seg_del_in(sdel), .run_in(run), .act_seg_in(act),
    .dac_data_out(dq), .dac_valid_out(dv), .seg_empty_out(semp));
  swp_dac_model u_dac (.core_clk_in(clk), .dac_data_in(dq), .dac_valid_in(dv),
    .level_out(lvl), .seen_out(seen));

  initial forever #20 clk = ~clk;
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tk(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // table write, refused numbers not recorded
  task automatic seg_wr(input int n, input int s, input int e);
    swr = 1;
    snum = n[11:0];
    sst = s[19:0];
    ssp = e[19:0];
    tk();
    swr = 0;
    tk();
    if (n >= 1 && n <= 2048) begin
      bs[n] = s;
      be[n] = e;
    end
  endtask
  // queue k wrapped words per channel, select, then run
  task automatic run_both(input int a, input int b, input int k);
    int w;
    for (int i = 0; i < k; i++) begin
      q0.push_back(mem_m[bs[a] + i % (be[a] - bs[a] + 1)]);
      q1.push_back(mem_m[bs[b] + i % (be[b] - bs[b] + 1)]);
    end
    act = {b[11:0], a[11:0]};
    tk(2);
    check({14'h0, semp}, 16'h0);
    run = 2'b11;
    w = 0;
    while (q0.size() + q1.size() > 0 && w < 60) begin
      tk();
      w++;
    end
    check(16'(q0.size() + q1.size()), 16'h0);
    run = 2'b00;
    tk(4);
  endtask
  // empty selection: no words reach the converter
  task automatic quiet(input int s);
    logic [15:0] c;
    logic [15:0] l;
    act[11:0] = s[11:0];
    run[0] = 1;
    tk(4);
    c = seen[15:0];
    l = lvl[15:0];
    tk(20);
    check(seen[15:0], c);
    check(lvl[15:0], l);
    check({15'h0, semp[0]}, 16'h1);
    run[0] = 0;
    tk(2);
  endtask
  // watcher: oldest note against each strobe while notes remain, plus hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (dv[0] === 1'b1 && q0.size() > 0) check(dq[15:0], q0.pop_front());
    if (dv[1] === 1'b1 && q1.size() > 0) check(dq[31:16], q1.pop_front());
    if (cyc == 4000) begin
      n_errors++;
      finish_test();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    tk(6);
    srst = 0;
    for (int i = 0; i < 17; i++) begin
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      maddr = (i < 16) ? 20'(i) : 20'hfffff;
      mdat = rs[15:0];
      mem_m[int'(maddr)] = rs[15:0];
      mwr = 1;
      tk();
    end
    mwr = 0;
    foreach (tbl[i]) seg_wr(tbl[i][0], tbl[i][1], tbl[i][2]);
    run_both(1, 2, 10);
    run_both(2048, 1, 6);
    quiet(0);
    quiet(2049);
    quiet(3);
    // delete with a table write in the same cycle: segment 2 survives
    sdel = 1;
    swr = 1;
    snum = 12'h002;
    sst = 20'h00008;
    ssp = 20'h0000a;
    tk();
    sdel = 0;
    swr = 0;
    tk();
    quiet(1);
    seg_wr(1, 2, 5);
    run_both(1, 2, 8);
    finish_test();
  end
endmodule

/* design/swp_chan.sv */
// Purpose: one channel's read address walker over its active segment
// Assumes: segment bounds already looked up by the caller
// Notes:   restarts at the segment start whenever the selection changes
`timescale 1ns/1ns
`include "swp_defs.svh"

module swp_chan #(
  parameter int AW = `SWP_MEM_AW_BASE
) (
  input  wire logic                 core_clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 tick_in,
  input  wire logic                 run_in,
  input  wire logic                 seg_ok_in,
  input  wire swp_pkg::swp_seg_num_t act_seg_in,
  input  wire logic [AW-1:0]        start_in,
  input  wire logic [AW-1:0]        stop_in,
  output logic [AW-1:0]             addr_out,
  output logic                      playing_out
);
  import swp_pkg::*;

  swp_state_t   state;
  swp_state_t   next_state;
  swp_seg_num_t last_seg;
  logic [AW-1:0] next_addr;
  wire          reselect;
  wire          at_stop;
  wire          go;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign reselect = (act_seg_in != last_seg);
  assign at_stop  = (addr_out == stop_in);
  assign go       = run_in && seg_ok_in;
  assign next_state = go ? SWP_PLAY : SWP_IDLE;
  // wrap from stop back to start, else step in memory order
  assign next_addr = (state == SWP_IDLE || reselect) ? start_in :
                     (at_stop ? start_in : addr_out + 1'b1);

  // state, selection memory and address
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state       <= SWP_IDLE;
      last_seg    <= '0;
      addr_out    <= '0;
      playing_out <= 1'b0;
    end else begin
      last_seg    <= act_seg_in;
      playing_out <= go && !reselect;
      unique case (state)
        SWP_IDLE: begin
          addr_out <= start_in;
          // wait one cycle after a new selection so the start word is not skipped
          state    <= reselect ? SWP_IDLE : next_state;
        end
        SWP_PLAY: begin
          if (!go) begin
            state <= SWP_IDLE;
          end else if (reselect) begin
            addr_out <= start_in;
            state    <= SWP_IDLE;
          end else if (tick_in) begin
            addr_out <= next_addr;
          end
        end
      endcase
    end
  end

endmodule

/* design/swp_defs.svh */
// Purpose: constants for the segmented waveform playback engine
// Assumes: included by bare name from every design file
// Notes:   widths and counts, field layout of a segment number
`ifndef SWP_DEFS_SVH
`define SWP_DEFS_SVH

// ------------------------------------------------------------
// sample word and memory
// ------------------------------------------------------------
`define SWP_SAMPLE_W      16
`define SWP_EFF_RES_BITS  14
`define SWP_MEM_AW_BASE   20
`define SWP_MEM_AW_EXP    21

// ------------------------------------------------------------
// segment table
// ------------------------------------------------------------
`define SWP_SEG_COUNT     2048
`define SWP_SEG_IDX_W     11
`define SWP_SEG_NUM_W     12
`define SWP_SEG_FIRST     12'h001

// ------------------------------------------------------------
// sample clock and channels
// ------------------------------------------------------------
`define SWP_CLK_HZ        25000000
`define SWP_SCLK_DIV      1
`define SWP_NUM_CH        2

`endif

/* design/swp_pkg.sv */
// Purpose: shared types for the segmented waveform playback engine
// Assumes: swp_defs.svh on the include path
// Notes:   constants live in the header, types live here
`include "swp_defs.svh"

package swp_pkg;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef logic [`SWP_SAMPLE_W-1:0]  swp_sample_t;
  typedef logic [`SWP_SEG_NUM_W-1:0] swp_seg_num_t;
  typedef logic [`SWP_SEG_IDX_W-1:0] swp_seg_idx_t;

  // player state
  typedef enum logic [0:0] {
    SWP_IDLE = 1'b0,
    SWP_PLAY = 1'b1
  } swp_state_t;

endpackage

/* design/swp_top.sv */
// Purpose: segmented waveform playback engine, multi-channel
// Assumes: host ports and converter are on core_clk_in (25 MHz)
// Notes:   one shared working memory, one segment table, per-channel players
`timescale 1ns/1ns
`include "swp_defs.svh"

module swp_top #(
  parameter int  NUM_CH   = `SWP_NUM_CH,
  parameter bit  MEM_EXP  = 1'b0,
  parameter int  SCLK_DIV = `SWP_SCLK_DIV,
  parameter int  AW       = MEM_EXP ? `SWP_MEM_AW_EXP : `SWP_MEM_AW_BASE
) (
  input  wire logic                              core_clk_in,
  input  wire logic                              srst_in,
  input  wire logic                              mem_wr_in,
  input  wire logic [AW-1:0]                     mem_addr_in,
  input  wire swp_pkg::swp_sample_t              mem_data_in,
  input  wire logic                              seg_wr_in,
  input  wire swp_pkg::swp_seg_num_t             seg_num_in,
  input  wire logic [AW-1:0]                     seg_start_in,
  input  wire logic [AW-1:0]                     seg_stop_in,
  input  wire logic                              seg_del_in,
  input  wire logic [NUM_CH-1:0]                 run_in,
  input  wire logic [NUM_CH*`SWP_SEG_NUM_W-1:0]  act_seg_in,
  output logic [NUM_CH*`SWP_SAMPLE_W-1:0]        dac_data_out,
  output logic [NUM_CH-1:0]                      dac_valid_out,
  output logic [NUM_CH-1:0]                      seg_empty_out
);
  import swp_pkg::*;

  localparam int DEPTH   = 1 << AW;
  localparam int DIV_W   = (SCLK_DIV > 1) ? $clog2(SCLK_DIV) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_DIV - 1);

  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  swp_sample_t   wave_mem  [DEPTH];
  logic [AW-1:0] seg_start [`SWP_SEG_COUNT];
  logic [AW-1:0] seg_stop  [`SWP_SEG_COUNT];
  logic [`SWP_SEG_COUNT-1:0] seg_defined;

  // ------------------------------------------------------------
  // host write decode
  // ------------------------------------------------------------
  wire          seg_num_ok;
  swp_seg_idx_t seg_wr_idx;
  wire          seg_wr_go;

  // numbers count from one; index is number minus one
  assign seg_num_ok = (seg_num_in >= `SWP_SEG_FIRST) &&
                      (seg_num_in <= `SWP_SEG_NUM_W'(`SWP_SEG_COUNT));
  assign seg_wr_idx = swp_seg_idx_t'(seg_num_in - `SWP_SEG_FIRST);
  assign seg_wr_go  = seg_wr_in && seg_num_ok;

  // sample memory write, never touched by delete
  always_ff @(posedge core_clk_in) begin
    if (mem_wr_in) begin
      wave_mem[mem_addr_in] <= mem_data_in;
    end
  end

  // segment bounds; rewriting after delete restores access
  always_ff @(posedge core_clk_in) begin
    if (seg_wr_go) begin
      seg_start[seg_wr_idx] <= seg_start_in;
      seg_stop[seg_wr_idx]  <= seg_stop_in;
    end
  end

  // defined flags: delete clears the table only, a write in the
  // same cycle still defines its entry
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      seg_defined <= '0;
    end else begin
      if (seg_del_in) begin
        seg_defined <= '0;
      end
      if (seg_wr_go) begin
        seg_defined[seg_wr_idx] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // sample clock enable divider
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  wire              samp_tick;

  assign samp_tick = (div_cnt == DIV_LAST);

  // one-cycle enable every SCLK_DIV clocks
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= samp_tick ? '0 : div_cnt + 1'b1;
    end
  end

  // ------------------------------------------------------------
  // per-channel players
  // ------------------------------------------------------------
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      swp_seg_num_t  act_num;
      swp_seg_idx_t  act_idx;
      wire           act_ok;
      logic [AW-1:0] rd_addr;
      wire           playing;

      // each channel has its own selection and walker
      assign act_num = act_seg_in[ch*`SWP_SEG_NUM_W +: `SWP_SEG_NUM_W];
      assign act_idx = swp_seg_idx_t'(act_num - `SWP_SEG_FIRST);
      // out-of-range or undefined segments stay silent
      assign act_ok  = (act_num >= `SWP_SEG_FIRST) &&
                       (act_num <= `SWP_SEG_NUM_W'(`SWP_SEG_COUNT)) &&
                       seg_defined[act_idx];

      swp_chan #(
        .AW (AW)
      ) u_chan (
        .core_clk_in (core_clk_in),
        .srst_in     (srst_in),
        .tick_in     (samp_tick),
        .run_in      (run_in[ch]),
        .seg_ok_in   (act_ok),
        .act_seg_in  (act_num),
        .start_in    (seg_start[act_idx]),
        .stop_in     (seg_stop[act_idx]),
        .addr_out    (rd_addr),
        .playing_out (playing)
      );

      // fetch the current word on each tick while playing; samples pass unscaled
      always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
          dac_data_out[ch*`SWP_SAMPLE_W +: `SWP_SAMPLE_W] <= '0;
          dac_valid_out[ch] <= 1'b0;
          seg_empty_out[ch] <= 1'b1;
        end else begin
          seg_empty_out[ch] <= !act_ok;
          dac_valid_out[ch] <= samp_tick && playing;
          if (samp_tick && playing) begin
            dac_data_out[ch*`SWP_SAMPLE_W +: `SWP_SAMPLE_W] <= wave_mem[rd_addr];
          end
        end
      end
    end
  endgenerate

endmodule
